// [logic/sfr_map.sv]
// special function register map behind an APB slave, with the indirect data port
// assumes one 40 MHz clock, a core that drives APB, and data memory answering in the cycle
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "sfr_params.svh"

module sfr_map
	import sfr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic brownout_detect,
	input wire logic ext_reset_pin_req,
	input wire logic wdt_timeout,
	input wire logic [3:0] periph_flag_set,
	input wire logic [2:0] int_flag_set,
	output logic [7:0] ind_addr,
	output logic [7:0] ind_wdata,
	output logic ind_we,
	input wire logic [7:0] ind_rdata,
	output logic [12:0] pc_out,
	output logic [7:0] status_out,
	output logic [7:0] option_out,
	output logic [7:0] int_ctrl_out,
	output logic [7:0] periph_flags_out,
	output logic [7:0] port_a_dir,
	output logic [7:0] port_b_dir,
	output logic [7:0] port_c_dir
);

	localparam logic [7:0] MIRROR [6] = '{`SFR_IDX_INDIRECT, `SFR_IDX_PC_LOW, `SFR_IDX_STATUS,
		`SFR_IDX_POINTER, `SFR_IDX_PC_UPPER, `SFR_IDX_INT_CTRL};

	sfr_state_t s_r;
	sfr_state_t s_nxt;
	logic [7:0] idx;
	logic [7:0] rd_val;
	logic map_hit;
	logic rd_setup;
	logic wr_acc;
	logic pwr_rst;
	logic other_rst;
	logic self_ptr;

	// both bank copies of a mirrored register fold onto one index
	always_comb begin
		idx = paddr[9:2];
		for (int k = 0; k < 6; k++) begin
			if (paddr[8:2] == MIRROR[k][6:0]) begin
				idx = MIRROR[k];
			end
		end
		if (paddr[11:10] != 2'b00) begin
			idx = 8'h7f; // outside the map, never decoded
		end
	end

	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr_acc = psel & penable & pwrite;
	assign pwr_rst = brownout_detect;
	assign other_rst = (ext_reset_pin_req | wdt_timeout) & ~brownout_detect;
	// pointer aimed at the indirect slot itself reads zero and writes nothing
	assign self_ptr = (s_r.indirect_pointer[6:0] == 7'h00);

	// read multiplexer; unknown index and hidden bits give zero
	always_comb begin
		map_hit = 1'b1;
		case (idx)
			`SFR_IDX_PC_UPPER: rd_val = s_r.pc_upper_latch;
			`SFR_IDX_INT_CTRL: rd_val = s_r.interrupt_control;
			`SFR_IDX_PIRQ_FLAGS: rd_val = s_r.peripheral_irq_flags;
			`SFR_IDX_T16_LOW: rd_val = s_r.timer16_low;
			`SFR_IDX_T16_HIGH: rd_val = s_r.timer16_high;
			`SFR_IDX_T16_CTRL: rd_val = s_r.timer16_control;
			`SFR_IDX_T8_COUNT: rd_val = s_r.timer8_count;
			`SFR_IDX_T8_CTRL: rd_val = s_r.timer8_control;
			`SFR_IDX_SER_BUF: rd_val = s_r.serial_port_buffer;
			`SFR_IDX_SER_CTRL: rd_val = s_r.serial_port_control;
			`SFR_IDX_CAP_LOW: rd_val = s_r.capture_low;
			`SFR_IDX_CAP_HIGH: rd_val = s_r.capture_high;
			`SFR_IDX_CAP_CTRL: rd_val = s_r.capture_control;
			`SFR_IDX_INDIRECT: rd_val = self_ptr ? 8'h00 : ind_rdata;
			`SFR_IDX_OPTION: rd_val = s_r.option_config;
			`SFR_IDX_PC_LOW: rd_val = s_r.pc[7:0];
			`SFR_IDX_STATUS: rd_val = s_r.core_status;
			`SFR_IDX_POINTER: rd_val = s_r.indirect_pointer;
			`SFR_IDX_DIR_A: rd_val = s_r.port_a_direction;
			`SFR_IDX_DIR_B: rd_val = s_r.port_b_direction;
			`SFR_IDX_DIR_C: rd_val = s_r.port_c_direction;
			default: begin
				rd_val = 8'h00;
				map_hit = 1'b0;
			end
		endcase
	end

	// next state: resets first, then bus write, then hardware flag sets
	always_comb begin
		s_nxt = s_r;
		s_nxt.ind_we = 1'b0;
		// read data is caught in the setup cycle so prdata comes from a flop
		if (rd_setup) begin
			s_nxt.rd_data = rd_val;
		end
		if (pwr_rst) begin
			s_nxt = '0;
			s_nxt.option_config = `SFR_RST_OPTION;
			s_nxt.core_status = `SFR_RST_STATUS;
			s_nxt.port_a_direction = `SFR_RST_DIR_A;
			s_nxt.port_b_direction = `SFR_RST_DIR_BC;
			s_nxt.port_c_direction = `SFR_RST_DIR_BC;
		end else if (other_rst) begin
			// second column: u fields keep their value
			s_nxt.pc_upper_latch = `SFR_RST_ZERO;
			s_nxt.interrupt_control = {7'h00, s_r.interrupt_control[0]};
			s_nxt.peripheral_irq_flags = `SFR_RST_ZERO;
			s_nxt.timer8_count = `SFR_RST_ZERO;
			s_nxt.timer8_control = `SFR_RST_ZERO;
			s_nxt.serial_port_control = `SFR_RST_ZERO;
			s_nxt.capture_control = `SFR_RST_ZERO;
			s_nxt.option_config = `SFR_RST_OPTION;
			s_nxt.pc = `SFR_RST_PC;
			s_nxt.port_a_direction = `SFR_RST_DIR_A;
			s_nxt.port_b_direction = `SFR_RST_DIR_BC;
			s_nxt.port_c_direction = `SFR_RST_DIR_BC;
			s_nxt.core_status[7:5] = 3'b000;
			// q bits: a watchdog timeout clears the timeout flag, a pin reset keeps both
			if (wdt_timeout) begin
				s_nxt.core_status[`SFR_ST_TIMEOUT] = 1'b0;
				s_nxt.core_status[`SFR_ST_POWERDOWN] = 1'b1;
			end
		end else begin
			// write lands at the completing edge of the access
			if (wr_acc) begin
				case (idx)
					`SFR_IDX_PC_UPPER: s_nxt.pc_upper_latch = pwdata[7:0] & `SFR_MASK_PC_UPPER;
					`SFR_IDX_INT_CTRL: s_nxt.interrupt_control = pwdata[7:0];
					`SFR_IDX_PIRQ_FLAGS: s_nxt.peripheral_irq_flags = pwdata[7:0] & `SFR_MASK_PIRQ;
					`SFR_IDX_T16_LOW: s_nxt.timer16_low = pwdata[7:0];
					`SFR_IDX_T16_HIGH: s_nxt.timer16_high = pwdata[7:0];
					`SFR_IDX_T16_CTRL: s_nxt.timer16_control = pwdata[7:0] & `SFR_MASK_T16_CTRL;
					`SFR_IDX_T8_COUNT: s_nxt.timer8_count = pwdata[7:0];
					`SFR_IDX_T8_CTRL: s_nxt.timer8_control = pwdata[7:0] & `SFR_MASK_T8_CTRL;
					`SFR_IDX_SER_BUF: s_nxt.serial_port_buffer = pwdata[7:0];
					`SFR_IDX_SER_CTRL: s_nxt.serial_port_control = pwdata[7:0];
					`SFR_IDX_CAP_LOW: s_nxt.capture_low = pwdata[7:0];
					`SFR_IDX_CAP_HIGH: s_nxt.capture_high = pwdata[7:0];
					`SFR_IDX_CAP_CTRL: s_nxt.capture_control = pwdata[7:0] & `SFR_MASK_CAP_CTRL;
					`SFR_IDX_INDIRECT: begin
						// no physical register: forward to data memory
						s_nxt.ind_we = ~self_ptr;
						s_nxt.ind_wdata = pwdata[7:0];
					end
					`SFR_IDX_OPTION: s_nxt.option_config = pwdata[7:0];
					// pc low write pulls the hidden upper bits from the latch
					`SFR_IDX_PC_LOW: s_nxt.pc = {s_r.pc_upper_latch[4:0], pwdata[7:0]};
					`SFR_IDX_STATUS: begin
						// timeout and power-down flags are not writable by software
						s_nxt.core_status = (pwdata[7:0] & `SFR_MASK_STATUS_WR)
							| (s_r.core_status & ~`SFR_MASK_STATUS_WR);
					end
					`SFR_IDX_POINTER: s_nxt.indirect_pointer = pwdata[7:0];
					`SFR_IDX_DIR_A: s_nxt.port_a_direction = pwdata[7:0] & `SFR_MASK_DIR_A;
					`SFR_IDX_DIR_B: s_nxt.port_b_direction = pwdata[7:0];
					`SFR_IDX_DIR_C: s_nxt.port_c_direction = pwdata[7:0];
					default: ;
				endcase
			end
			// set beats a software clear in the same cycle
			s_nxt.peripheral_irq_flags[3:0] = s_nxt.peripheral_irq_flags[3:0] | periph_flag_set;
			s_nxt.interrupt_control[2:0] = s_nxt.interrupt_control[2:0] | int_flag_set;
		end
	end

	// power-on values under the asynchronous reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.option_config <= `SFR_RST_OPTION;
			s_r.core_status <= `SFR_RST_STATUS;
			s_r.port_a_direction <= `SFR_RST_DIR_A;
			s_r.port_b_direction <= `SFR_RST_DIR_BC;
			s_r.port_c_direction <= `SFR_RST_DIR_BC;
		end else begin
			s_r <= s_nxt;
		end
	end

	// zero-wait slave: every access finishes in its first access cycle
	assign pready = psel & penable;
	assign pslverr = 1'b0; // unmapped reads answer zero, not an error
	assign prdata = {24'h000000, s_r.rd_data};
	assign ind_addr = s_r.indirect_pointer;
	assign ind_wdata = s_r.ind_wdata;
	assign ind_we = s_r.ind_we;
	assign pc_out = s_r.pc;
	assign status_out = s_r.core_status;
	assign option_out = s_r.option_config;
	assign int_ctrl_out = s_r.interrupt_control;
	assign periph_flags_out = s_r.peripheral_irq_flags;
	assign port_a_dir = s_r.port_a_direction;
	assign port_b_dir = s_r.port_b_direction;
	assign port_c_dir = s_r.port_c_direction;

	// checks that guard the map
	chk_unmapped_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rd_setup && !map_hit |=> prdata == 32'h00000000)
		else $error("unmapped read returned nonzero");

	chk_mirror_status_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rd_setup && (paddr[9:2] == 8'h03 || paddr[9:2] == 8'h83) && paddr[11:10] == 2'b00
		&& !pwr_rst |=> prdata[7:0] == $past(s_r.core_status))
		else $error("status not mirrored in both banks");

	chk_latch_into_pc: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_acc && idx == `SFR_IDX_PC_LOW && !pwr_rst && !other_rst
		|=> pc_out == {$past(s_r.pc_upper_latch[4:0]), $past(pwdata[7:0])})
		else $error("pc upper bits not taken from latch");

	chk_indirect_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_acc && idx == `SFR_IDX_INDIRECT && !self_ptr && !pwr_rst && !other_rst
		|=> ind_we && ind_addr == $past(s_r.indirect_pointer) && ind_wdata == $past(pwdata[7:0])
		##1 !ind_we)
		else $error("indirect write not forwarded once");

	chk_indirect_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rd_setup && idx == `SFR_IDX_INDIRECT && !self_ptr && !pwr_rst
		|=> prdata[7:0] == $past(ind_rdata))
		else $error("indirect read not from data memory");

	chk_other_reset_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b)
		other_rst |=> s_r.timer16_control == $past(s_r.timer16_control) && pc_out == 13'h0000
		&& option_out == 8'hff)
		else $error("pin or watchdog reset loaded wrong column");

	chk_brownout_loads_por: assert property (@(posedge sys_clk) disable iff (!rst_b)
		pwr_rst |=> status_out == 8'h18 && s_r.timer16_control == 8'h00 && port_a_dir == 8'h3f)
		else $error("brown-out did not load power-up values");

	chk_status_u_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
		other_rst |=> status_out[7:5] == 3'b000 && status_out[2:0] == $past(status_out[2:0])
		&& int_ctrl_out[0] == $past(int_ctrl_out[0]))
		else $error("unchanged bits lost on non-power-up reset");

	chk_write_one_access: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_acc && idx == `SFR_IDX_DIR_B && !pwr_rst && !other_rst
		|-> pready ##1 port_b_dir == $past(pwdata[7:0]))
		else $error("write not effective by end of access");

	chk_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
		periph_flag_set[0] && !pwr_rst && !other_rst |=> periph_flags_out[0])
		else $error("hardware flag set lost");

	chk_unmapped_write_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_acc && !map_hit && !pwr_rst && !other_rst
		|=> $stable(status_out) && $stable(option_out) && $stable(pc_out) && !ind_we)
		else $error("write to an unmapped location changed state");

	chk_hidden_bits_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_r.pc_upper_latch[7:5] == 3'b000 && s_r.peripheral_irq_flags[5:4] == 2'b00
		&& s_r.port_a_direction[7:6] == 2'b00 && s_r.timer8_control[7] == 1'b0)
		else $error("unimplemented register bit holds a one");

	chk_read_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		prdata[31:8] == 24'h000000)
		else $error("read data above the low byte not zero");

	chk_mirror_latch_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rd_setup && paddr[8:2] == 7'h0a && paddr[11:10] == 2'b00 && !pwr_rst
		|=> prdata[7:0] == $past(s_r.pc_upper_latch))
		else $error("pc latch not mirrored in both banks");

	chk_mirror_pointer_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_acc && paddr[8:2] == 7'h04 && paddr[11:10] == 2'b00 && !pwr_rst && !other_rst
		|=> ind_addr == $past(pwdata[7:0]))
		else $error("pointer write not reaching one register from both banks");

	chk_pc_only_by_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!(wr_acc && idx == `SFR_IDX_PC_LOW) && !pwr_rst && !other_rst |=> $stable(pc_out))
		else $error("pc moved without a pc low write");

	chk_self_pointer_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_acc && idx == `SFR_IDX_INDIRECT && self_ptr |=> !ind_we)
		else $error("indirect write through the indirect slot reached memory");

	chk_pin_reset_q_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
		other_rst && !wdt_timeout |=> status_out[4:3] == $past(status_out[4:3]))
		else $error("pin reset changed the timeout or power-down flag");

	chk_watchdog_q_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wdt_timeout && !pwr_rst |=> status_out[4:3] == 2'b01)
		else $error("watchdog reset left wrong timeout flags");

	chk_read_data_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!rd_setup && !pwr_rst |=> $stable(prdata))
		else $error("read data changed outside a read setup");

endmodule // sfr_map

// [shared/sfr_params.svh]
// offsets, field masks, reset values and timing of the special function register map
// assumes an APB slave with 32-bit data; register index times four is the byte address
// Operation
// - unimplemented addresses and bits read back as zero
// - indirect, pc low, status, pointer, pc latch, interrupt control mirror in both banks
// - pc upper bits hidden; 5-bit latch loads pc bits 12..8 on pc update
// - pin or watchdog reset loads second column; power-up and brown-out load first
// - u bits hold over non-power-up reset, x undefined, q depends on cause
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// register indices (byte address is index * 4)
`define SFR_IDX_PC_UPPER 8'h0a
`define SFR_IDX_INT_CTRL 8'h0b
`define SFR_IDX_PIRQ_FLAGS 8'h0c
`define SFR_IDX_T16_LOW 8'h0e
`define SFR_IDX_T16_HIGH 8'h0f
`define SFR_IDX_T16_CTRL 8'h10
`define SFR_IDX_T8_COUNT 8'h11
`define SFR_IDX_T8_CTRL 8'h12
`define SFR_IDX_SER_BUF 8'h13
`define SFR_IDX_SER_CTRL 8'h14
`define SFR_IDX_CAP_LOW 8'h15
`define SFR_IDX_CAP_HIGH 8'h16
`define SFR_IDX_CAP_CTRL 8'h17
`define SFR_IDX_INDIRECT 8'h80
`define SFR_IDX_OPTION 8'h81
`define SFR_IDX_PC_LOW 8'h82
`define SFR_IDX_STATUS 8'h83
`define SFR_IDX_POINTER 8'h84
`define SFR_IDX_DIR_A 8'h85
`define SFR_IDX_DIR_B 8'h86
`define SFR_IDX_DIR_C 8'h87

// implemented-bit masks, and the software-writable status bits
`define SFR_MASK_PC_UPPER 8'h1f
`define SFR_MASK_PIRQ 8'hcf
`define SFR_MASK_T16_CTRL 8'h3f
`define SFR_MASK_T8_CTRL 8'h7f
`define SFR_MASK_CAP_CTRL 8'h3f
`define SFR_MASK_DIR_A 8'h3f
`define SFR_MASK_STATUS_WR 8'he7

// status field positions
`define SFR_ST_TIMEOUT 4
`define SFR_ST_POWERDOWN 3

// reset values (first column; x bits taken as zero)
`define SFR_RST_ZERO 8'h00
`define SFR_RST_OPTION 8'hff
`define SFR_RST_STATUS 8'h18
`define SFR_RST_DIR_A 8'h3f
`define SFR_RST_DIR_BC 8'hff
`define SFR_RST_PC 13'h0000

// cycles from setup to answer
`define SFR_WAIT_CYCLES 1

`endif

// [shared/sfr_pkg.sv]
// types for the special function register map
// assumes sfr_params.svh supplies the numbers
package sfr_pkg;

	typedef struct packed {
		logic [7:0] pc_upper_latch;
		logic [7:0] interrupt_control;
		logic [7:0] peripheral_irq_flags;
		logic [7:0] timer16_low;
		logic [7:0] timer16_high;
		logic [7:0] timer16_control;
		logic [7:0] timer8_count;
		logic [7:0] timer8_control;
		logic [7:0] serial_port_buffer;
		logic [7:0] serial_port_control;
		logic [7:0] capture_low;
		logic [7:0] capture_high;
		logic [7:0] capture_control;
		logic [7:0] option_config;
		logic [12:0] pc;
		logic [7:0] core_status;
		logic [7:0] indirect_pointer;
		logic [7:0] port_a_direction;
		logic [7:0] port_b_direction;
		logic [7:0] port_c_direction;
		logic [7:0] rd_data;
		logic ind_we;
		logic [7:0] ind_wdata;
	} sfr_state_t;

endpackage

// [verif/sfr_mem_model.sv]
// data memory behind the indirect port, as the core's data space sees it
// assumes the map drives ind_addr and a one-cycle ind_we from sys_clk
`timescale 1ns/100ps

module sfr_mem_model (
	input wire logic sys_clk,
	input wire logic [7:0] ind_addr,
	input wire logic [7:0] ind_wdata,
	input wire logic ind_we,
	output logic [7:0] ind_rdata
);
	logic [7:0] mem [0:255];

	// known pattern so an indirect read before any write is still checkable
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end

	// one whole byte per write strobe
	always @(posedge sys_clk) begin
		if (ind_we === 1'b1) begin
			mem[ind_addr] <= ind_wdata;
		end
	end

	// answers in the same cycle, as the map samples it at setup
	assign ind_rdata = mem[ind_addr];
endmodule // sfr_mem_model

// [verif/special_function_register_map_tb.sv]
// self-checking bench for the special function register map over APB
// assumes sfr_map, the data memory model and a 40 MHz single clock
`timescale 1ns/100ps

module special_function_register_map_tb;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic brownout_detect = 1'b0, ext_reset_pin_req = 1'b0, wdt_timeout = 1'b0;
	logic [3:0] periph_flag_set = 4'h0;
	logic [2:0] int_flag_set = 3'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ind_we;
	logic last_err = 1'b1;
	logic [7:0] ind_addr, ind_wdata, ind_rdata, status_out, option_out, int_ctrl_out;
	logic [7:0] periph_flags_out, port_a_dir, port_b_dir, port_c_dir;
	logic [12:0] pc_out;
	int bad_count = 0;
	int check_count = 0;
	// mapped registers, implemented bits and power-up values
	localparam logic [7:0] reg_idx [19] = '{8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87};
	localparam logic [7:0] reg_msk [19] = '{8'h1f, 8'hff, 8'hcf, 8'hff, 8'hff, 8'h3f, 8'hff,
		8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
	localparam logic [7:0] reg_rst [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h3f, 8'hff, 8'hff};
	// locations with no register behind them in either bank
	localparam logic [7:0] gap_idx [5] = '{8'h08, 8'h0d, 8'h1c, 8'h89, 8'h8d};

	sfr_map uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .brownout_detect(brownout_detect),
		.ext_reset_pin_req(ext_reset_pin_req), .wdt_timeout(wdt_timeout),
		.periph_flag_set(periph_flag_set), .int_flag_set(int_flag_set), .ind_addr(ind_addr),
		.ind_wdata(ind_wdata), .ind_we(ind_we), .ind_rdata(ind_rdata), .pc_out(pc_out),
		.status_out(status_out), .option_out(option_out), .int_ctrl_out(int_ctrl_out),
		.periph_flags_out(periph_flags_out), .port_a_dir(port_a_dir),
		.port_b_dir(port_b_dir), .port_c_dir(port_c_dir));

	sfr_mem_model mem (.sys_clk(sys_clk), .ind_addr(ind_addr), .ind_wdata(ind_wdata),
		.ind_we(ind_we), .ind_rdata(ind_rdata));

	// 25 ns period
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t value got %h exp %h", $time, got, exp);
		end
	endtask

	// one APB transfer; waits for pready however long the slave takes
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, {2'b00, idx, 2'b00}, d, q);
	endtask

	// upper 24 bits must read zero as well
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, q);
		chk(q, {24'h0, exp});
	endtask

	// one-cycle pulse on a reset source: 0 pin, 1 watchdog, 2 brown-out
	task automatic pulse(input int k);
		@(posedge sys_clk);
		ext_reset_pin_req <= (k == 0);
		wdt_timeout <= (k == 1);
		brownout_detect <= (k == 2);
		@(posedge sys_clk);
		ext_reset_pin_req <= 1'b0;
		wdt_timeout <= 1'b0;
		brownout_detect <= 1'b0;
		#1;
	endtask

	initial begin
		logic [7:0] d, p, s, t, ic;
		logic [31:0] q;
		void'($urandom(32'h99c6));
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 19; i++) begin
			rdc(reg_idx[i], reg_rst[i]);
		end
		rdc(8'h03, 8'h18);
		rdc(8'h80, 8'h00);
		// unimplemented locations swallow writes
		foreach (gap_idx[i]) begin
			wr(gap_idx[i], 8'($urandom));
			rdc(gap_idx[i], 8'h00);
		end
		// flag word outside this map: its brown-out bit is kept written as one
		wr(8'h8e, 8'h01);
		rdc(8'h8e, 8'h00);
		// random data through every listed register, the four mirrored ones read back from both banks
		repeat (3) begin
			for (int i = 0; i < 19; i++) begin
				d = 8'($urandom);
				if (reg_idx[i] == 8'h0c) d = d & 8'h3f;
				wr(reg_idx[i], d);
				rdc(reg_idx[i], d & reg_msk[i]);
				if (reg_idx[i] inside {8'h0a, 8'h0b, 8'h82, 8'h84})
					rdc(reg_idx[i] ^ 8'h80, d & reg_msk[i]);
			end
		end
		apb(1'b0, 12'h428, 8'h00, q);
		chk(q, 32'h0);
		chk(last_err, 1'b0);
		s = 8'($urandom) & 8'h27;
		wr(8'h03, s);
		rdc(8'h83, s | 8'h18);
		// latch reaches pc bits 12..8 only through a pc low write
		t = 8'($urandom);
		wr(8'h8a, t);
		d = 8'($urandom);
		wr(8'h02, d);
		chk(pc_out, {19'h0, t[4:0], d});
		// indirect port against the memory model
		p = 8'($urandom) | 8'h01;
		wr(8'h84, p);
		chk(ind_addr, p);
		rdc(8'h00, p ^ 8'h5a);
		d = 8'($urandom);
		wr(8'h80, d);
		chk({ind_we, ind_wdata}, {1'b1, d});
		@(posedge sys_clk);
		#1;
		chk(ind_we, 1'b0);
		rdc(8'h80, d);
		wr(8'h04, 8'h80);
		rdc(8'h00, 8'h00);
		wr(8'h80, 8'h33);
		chk(ind_we, 1'b0);
		// reset sources: u bits kept on pin and watchdog, cleared on brown-out
		p = 8'($urandom);
		t = 8'($urandom);
		ic = 8'($urandom) | 8'h01;
		wr(8'h84, p);
		wr(8'h0e, t);
		wr(8'h0b, ic);
		wr(8'h81, 8'h00);
		wr(8'h85, 8'h00);
		pulse(0);
		chk({port_b_dir, port_c_dir}, 16'hffff);
		chk({option_out, port_a_dir, status_out}, {16'hff3f, 3'b000, 2'b11, s[2:0]});
		chk({int_ctrl_out, pc_out}, {8'h01, 13'h0});
		rdc(8'h84, p);
		rdc(8'h0e, t);
		rdc(8'h0a, 8'h00);
		pulse(1);
		chk(status_out, {3'b000, 2'b01, s[2:0]});
		pulse(2);
		chk({status_out, int_ctrl_out}, {8'h18, 8'h00});
		rdc(8'h04, 8'h00);
		rdc(8'h0e, 8'h00);
		// hardware flag sets
		@(posedge sys_clk);
		periph_flag_set <= 4'ha;
		int_flag_set <= 3'h5;
		@(posedge sys_clk);
		periph_flag_set <= 4'h0;
		int_flag_set <= 3'h0;
		#1;
		chk({periph_flags_out, int_ctrl_out}, {8'h0a, 8'h05});
		rdc(8'h0c, 8'h0a);
		complete_run();
	end

	// the whole run needs a few hundred cycles; this is ample headroom
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
endmodule // special_function_register_map_tb
